// file: design/phy_status_summary_upper.sv
// Status summary word, upper half, with its home registers and interrupt
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Function
// RULE_01: Top bit ignores writes, reads zero
// RULE_02: Crossover bit one when pairs swapped
// RULE_03: Crossover bit follows enable, force, live swaps
// RULE_04: Receive error latch holds until cleared
// RULE_05: Receive error counter read clears latch
// RULE_06: Polarity mirrors tenbase bit, cleared there
// RULE_07: False carrier latch cleared by counter read
// RULE_08: Signal detect qualified by lock when enabled
// RULE_09: Detect and lock latch low, reset zero
// RULE_10: Page received copies expansion flag, cleared there
// RULE_11: Interrupt bit pending until status read
// RULE_12: Summary read clears no source
module phy_status_summary_upper #(
	parameter int CNT_W = phy_status_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic                              i_clock,
	input  wire logic                              i_nrst,
	// Register port
	input  wire logic [phy_status_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [phy_status_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                              i_wr,
	input  wire logic                              i_rd,
	output logic      [phy_status_pkg::DATA_W-1:0] o_rdata,
	// Status sources
	input  wire logic                              i_auto_swap,
	input  wire logic                              i_rx_error_event,
	input  wire logic                              i_false_carrier_event,
	input  wire logic                              i_polarity_inverted,
	input  wire logic                              i_raw_signal_detect,
	input  wire logic                              i_descrambler_lock,
	input  wire logic                              i_page_received,
	// Outputs to the rest of the PHY
	output logic                                   o_crossover_swapped,
	output logic                                   o_link_signal_detect,
	output logic                                   o_irq
);
	import phy_status_pkg::*;

	// ****************
	// Address decode
	// ****************
	function automatic logic hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] r,
		input logic              s
	);
		return s && (a == r);
	endfunction : hit

	logic rd_summary;
	logic rd_rxe;
	logic rd_fc;
	logic rd_ten;
	logic rd_neg;
	logic rd_irq;
	logic wr_pcs;
	logic wr_phy;
	logic wr_mask;

	assign rd_summary = hit(i_addr, ADDR_SUMMARY, i_rd);
	assign rd_rxe     = hit(i_addr, ADDR_RXE_CNT, i_rd);
	assign rd_fc      = hit(i_addr, ADDR_FC_CNT, i_rd);
	assign rd_ten     = hit(i_addr, ADDR_TENBASE, i_rd);
	assign rd_neg     = hit(i_addr, ADDR_NEG_EXP, i_rd);
	assign rd_irq     = hit(i_addr, ADDR_IRQ_STAT, i_rd);
	assign wr_pcs     = hit(i_addr, ADDR_PCS_CTRL, i_wr);
	assign wr_phy     = hit(i_addr, ADDR_PHY_CTRL, i_wr);
	assign wr_mask    = hit(i_addr, ADDR_IRQ_MASK, i_wr);

	// ****************
	// Control registers
	// ****************
	logic             qual_q;
	logic             auto_q;
	logic             force_q;
	logic [IRQ_W-1:0] mask_q;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			qual_q <= QUAL_RST;
		end else if (wr_pcs) begin
			qual_q <= i_wdata[PCS_QUAL];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			auto_q  <= AUTO_RST;
			force_q <= FORCE_RST;
		end else if (wr_phy) begin
			auto_q  <= i_wdata[PHYC_AUTO];
			force_q <= i_wdata[PHYC_FORCE];
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			mask_q <= MASK_RST;
		end else if (wr_mask) begin
			mask_q <= i_wdata[IRQ_W-1:0];
		end
	end

	// ****************
	// Crossover state
	// ****************
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_crossover_swapped <= 1'b0;
		end else if (force_q) begin
			o_crossover_swapped <= 1'b1; // RULE_02
		end else begin
			o_crossover_swapped <= auto_q & i_auto_swap; // RULE_03
		end
	end

	// ****************
	// Event latches and counters
	// ****************
	logic             rxe_q;
	logic             fc_q;
	logic             pol_q;
	logic             page_q;
	logic [CNT_W-1:0] rxe_cnt_q;
	logic [CNT_W-1:0] fc_cnt_q;

	// An event in the clearing cycle keeps the latch set
	// Summary reads reach none of these latches
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rxe_q <= 1'b0;
		end else begin
			rxe_q <= i_rx_error_event | (rxe_q & ~rd_rxe); // RULE_04 RULE_05 RULE_12
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			fc_q <= 1'b0;
		end else begin
			fc_q <= i_false_carrier_event | (fc_q & ~rd_fc); // RULE_07
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			pol_q <= 1'b0;
		end else begin
			pol_q <= i_polarity_inverted | (pol_q & ~rd_ten); // RULE_06
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			page_q <= 1'b0;
		end else begin
			page_q <= i_page_received | (page_q & ~rd_neg); // RULE_10
		end
	end

	// Counters saturate and restart from the pending event on read
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			rxe_cnt_q <= '0;
		end else if (rd_rxe) begin
			rxe_cnt_q <= {{(CNT_W-1){1'b0}}, i_rx_error_event};
		end else if (i_rx_error_event && !(&rxe_cnt_q)) begin
			rxe_cnt_q <= rxe_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			fc_cnt_q <= '0;
		end else if (rd_fc) begin
			fc_cnt_q <= {{(CNT_W-1){1'b0}}, i_false_carrier_event};
		end else if (i_false_carrier_event && !(&fc_cnt_q)) begin
			fc_cnt_q <= fc_cnt_q + 1'b1;
		end
	end

	// ****************
	// Signal detect and lock, latch low
	// ****************
	logic sd_live;
	logic sd_ll_q;
	logic lock_ll_q;

	assign sd_live = i_raw_signal_detect & (i_descrambler_lock | ~qual_q); // RULE_08

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_link_signal_detect <= 1'b0;
		end else begin
			o_link_signal_detect <= sd_live;
		end
	end

	// A summary read reloads the live level; otherwise a loss sticks
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sd_ll_q   <= 1'b0;
			lock_ll_q <= 1'b0;
		end else if (rd_summary) begin
			sd_ll_q   <= sd_live; // RULE_09
			lock_ll_q <= i_descrambler_lock;
		end else begin
			sd_ll_q   <= sd_ll_q & sd_live;
			lock_ll_q <= lock_ll_q & i_descrambler_lock;
		end
	end

	// ****************
	// Interrupt status and pending level
	// ****************
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] irq_stat_q;

	always_comb begin
		ev             = '0;
		ev[IRQ_RXERR]  = i_rx_error_event;
		ev[IRQ_FC]     = i_false_carrier_event;
		ev[IRQ_PAGE]   = i_page_received;
		ev[IRQ_SDLOSS] = o_link_signal_detect & ~sd_live;
	end

	for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
		always_ff @(posedge i_clock or negedge i_nrst) begin
			if (!i_nrst) begin
				irq_stat_q[i] <= 1'b0;
			end else begin
				irq_stat_q[i] <= ev[i] | (irq_stat_q[i] & ~rd_irq); // RULE_11
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_q & mask_q);
		end
	end

	// ****************
	// Read data
	// ****************
	logic [DATA_W-1:0] rdata_d;

	always_comb begin
		rdata_d = '0;
		case (i_addr)
			ADDR_SUMMARY: begin
				rdata_d[SUM_RSVD]  = 1'b0; // RULE_01
				rdata_d[SUM_XOVER] = o_crossover_swapped;
				rdata_d[SUM_RXERR] = rxe_q;
				rdata_d[SUM_POL]   = pol_q;
				rdata_d[SUM_FC]    = fc_q;
				rdata_d[SUM_SD]    = sd_ll_q;
				rdata_d[SUM_LOCK]  = lock_ll_q;
				rdata_d[SUM_PAGE]  = page_q;
				rdata_d[SUM_IRQ]   = o_irq;
			end
			ADDR_NEG_EXP:  rdata_d[NEG_PAGE] = page_q;
			ADDR_TENBASE:  rdata_d[TEN_POL] = pol_q;
			ADDR_RXE_CNT:  rdata_d[CNT_W-1:0] = rxe_cnt_q;
			ADDR_FC_CNT:   rdata_d[CNT_W-1:0] = fc_cnt_q;
			ADDR_PCS_CTRL: rdata_d[PCS_QUAL] = qual_q;
			ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
			ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
			ADDR_PHY_CTRL: begin
				rdata_d[PHYC_AUTO]  = auto_q;
				rdata_d[PHYC_FORCE] = force_q;
			end
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	top_zero_a: assert property (rd_summary |=> o_rdata[SUM_RSVD] == 1'b0) // RULE_01
		else $error("summary top bit not zero");
	xover_force_a: assert property (force_q |=> o_crossover_swapped) // RULE_02
		else $error("forced crossover not reported");
	xover_track_a: assert property ((auto_q && !force_q) |=> o_crossover_swapped == $past(i_auto_swap)) // RULE_03
		else $error("crossover bit not tracking swap");
	rxerr_hold_a: assert property (i_rx_error_event ##1 !rd_rxe [*2] |=> rxe_q) // RULE_04
		else $error("receive error latch lost");
	rxerr_clear_a: assert property ((rd_rxe && !i_rx_error_event) |=> !rxe_q) // RULE_05
		else $error("receive error latch not cleared");
	pol_mirror_a: assert property ((i_polarity_inverted ##1 rd_summary) |=> o_rdata[SUM_POL]) // RULE_06
		else $error("polarity not mirrored");
	fc_clear_a: assert property ((rd_fc && !i_false_carrier_event) ##1 rd_summary |=> !o_rdata[SUM_FC]) // RULE_07
		else $error("false carrier latch not cleared");
	sd_qual_a: assert property ((qual_q && !i_descrambler_lock) |=> !o_link_signal_detect) // RULE_08
		else $error("unqualified detect passed");
	sd_latch_a: assert property ((!sd_live ##1 !rd_summary [*2]) |=> !sd_ll_q) // RULE_09
		else $error("detect loss not held");
	page_clear_a: assert property ((rd_neg && !i_page_received) |=> !page_q) // RULE_10
		else $error("page flag not cleared");
	irq_level_a: assert property ((|(irq_stat_q & mask_q)) |=> o_irq) // RULE_11
		else $error("interrupt not raised");
	no_side_a: assert property (rd_summary |=> (rxe_q || !$past(rxe_q)) && (fc_q || !$past(fc_q)) // RULE_12
		&& (pol_q || !$past(pol_q)) && (page_q || !$past(page_q)))
		else $error("summary read cleared a source");
	xover_normal_a: assert property ((!auto_q && !force_q) |=> !o_crossover_swapped) // RULE_02
		else $error("crossover bit set with pairs normal");
	pol_clear_a: assert property ((rd_ten && !i_polarity_inverted) |=> !pol_q) // RULE_06
		else $error("polarity latch not cleared");
	fc_set_a: assert property (i_false_carrier_event |=> fc_q) // RULE_07
		else $error("false carrier latch not set");
	irq_drop_a: assert property (!(|(irq_stat_q & mask_q)) |=> !o_irq) // RULE_11
		else $error("interrupt raised with nothing pending");

	rx_err_c: cover property (i_rx_error_event ##1 rd_summary ##1 rd_rxe);
	sd_loss_c: cover property (sd_ll_q ##1 !sd_live ##[1:20] rd_summary);
	irq_c: cover property (o_irq ##1 rd_irq ##2 !o_irq);
	xover_force_c: cover property ((force_q && auto_q) ##1 o_crossover_swapped);
	set_wins_c: cover property ((i_rx_error_event && rd_rxe) ##1 rxe_q);

endmodule : phy_status_summary_upper

`default_nettype wire

// file: design/phy_status_pkg.sv
// Constants for the status summary word and its home registers
package phy_status_pkg;

	// ****************
	// Widths
	// ****************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 8;
	localparam int IRQ_W  = 4;

	// ****************
	// Register addresses
	// ****************
	localparam logic [ADDR_W-1:0] ADDR_NEG_EXP  = 5'h06;
	localparam logic [ADDR_W-1:0] ADDR_SUMMARY  = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h12;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h13;
	localparam logic [ADDR_W-1:0] ADDR_FC_CNT   = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_RXE_CNT  = 5'h15;
	localparam logic [ADDR_W-1:0] ADDR_PCS_CTRL = 5'h16;
	localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 5'h19;
	localparam logic [ADDR_W-1:0] ADDR_TENBASE  = 5'h1A;

	// ****************
	// Field positions
	// ****************
	localparam int SUM_RSVD   = 15;
	localparam int SUM_XOVER  = 14;
	localparam int SUM_RXERR  = 13;
	localparam int SUM_POL    = 12;
	localparam int SUM_FC     = 11;
	localparam int SUM_SD     = 10;
	localparam int SUM_LOCK   = 9;
	localparam int SUM_PAGE   = 8;
	localparam int SUM_IRQ    = 7;
	localparam int TEN_POL    = 4;
	localparam int NEG_PAGE   = 1;
	localparam int PCS_QUAL   = 8;
	localparam int PHYC_AUTO  = 15;
	localparam int PHYC_FORCE = 14;
	localparam int IRQ_RXERR  = 0;
	localparam int IRQ_FC     = 1;
	localparam int IRQ_PAGE   = 2;
	localparam int IRQ_SDLOSS = 3;

	// ****************
	// Values after reset
	// ****************
	localparam logic             QUAL_RST  = 1'b0;
	localparam logic             AUTO_RST  = 1'b1;
	localparam logic             FORCE_RST = 1'b0;
	localparam logic [IRQ_W-1:0] MASK_RST  = 4'h0;

endpackage : phy_status_pkg

// file: bench/tb_phy_status_summary_upper.sv
// Self-checking bench for the upper status summary word and its home registers
`timescale 1ns/100ps
`default_nettype none

module tb_phy_status_summary_upper;
	import phy_status_pkg::*;

	// ****************
	// Signals
	// ****************
	logic              i_clock;
	logic              i_nrst;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic [DATA_W-1:0] o_rdata;
	logic              swap;
	logic [3:0]        ev;
	logic              raw_sd;
	logic              lock;
	logic              o_crossover_swapped;
	logic              o_link_signal_detect;
	logic              o_irq;
	logic [DATA_W-1:0] d;
	int                errors;
	int                checked;
	int                cycles;

	// Event codes: 0 rx error, 1 false carrier, 2 polarity, 3 page
	logic [ADDR_W-1:0] home_a [4] = '{ADDR_RXE_CNT, ADDR_FC_CNT, ADDR_TENBASE, ADDR_NEG_EXP};
	int                sum_b  [4] = '{SUM_RXERR, SUM_FC, SUM_POL, SUM_PAGE};
	logic [DATA_W-1:0] home_v [4] = '{16'h0002, 16'h0002, 16'h0010, 16'h0002};

	phy_status_summary_upper #(.CNT_W(CNT_W)) DUT (
		.i_clock               (i_clock),
		.i_nrst                (i_nrst),
		.i_addr                (i_addr),
		.i_wdata               (i_wdata),
		.i_wr                  (i_wr),
		.i_rd                  (i_rd),
		.o_rdata               (o_rdata),
		.i_auto_swap           (swap),
		.i_rx_error_event      (ev[0]),
		.i_false_carrier_event (ev[1]),
		.i_polarity_inverted   (ev[2]),
		.i_raw_signal_detect   (raw_sd),
		.i_descrambler_lock    (lock),
		.i_page_received       (ev[3]),
		.o_crossover_swapped   (o_crossover_swapped),
		.o_link_signal_detect  (o_link_signal_detect),
		.o_irq                 (o_irq)
	);

	// ****************
	// Clock and timeout
	// ****************
	initial i_clock = 1'b0;
	always #25 i_clock = ~i_clock;

	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			test_done();
		end
	end

	// ****************
	// Tasks
	// ****************
	task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : tick

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= v;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask : wr

	// Data stand only in the cycle after the strobe edge
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask : rd

	task automatic pulse(input int b, input int n);
		ev[b] <= 1'b1;
		repeat (n) @(posedge i_clock);
		ev[b] <= 1'b0;
		#1;
	endtask : pulse

	task automatic xo(input logic [DATA_W-1:0] ctrl, input logic s, input logic exp);
		swap <= s;
		wr(ADDR_PHY_CTRL, ctrl);
		tick(2);
		chk("crossover", {15'h0000, o_crossover_swapped}, {15'h0000, exp});
		rd(ADDR_SUMMARY, d);
		chk("sum_xover", d, {1'b0, exp, 14'h0000});
	endtask : xo

	task automatic test_done();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// ****************
	// Tests
	// ****************
	initial begin
		errors = 0; checked = 0; cycles = 0;
		i_nrst = 1'b0; i_addr = '0; i_wdata = '0; i_wr = 1'b0; i_rd = 1'b0;
		swap = 1'b0; ev = 4'h0; raw_sd = 1'b0; lock = 1'b0;
		repeat (3) @(posedge i_clock);
		i_nrst <= 1'b1;
		tick(1);
		rd(ADDR_SUMMARY, d);
		chk("sum_reset", d, 16'h0000);
		tick(1);
		chk("rdata_idle", o_rdata, 16'h0000);
		wr(ADDR_SUMMARY, 16'hFFFF);
		rd(ADDR_SUMMARY, d);
		chk("sum_wr_ignored", d, 16'h0000);
		rd(5'h1F, d);
		chk("unmapped", d, 16'h0000);
		xo(16'h8000, 1'b1, 1'b1);
		xo(16'h0000, 1'b1, 1'b0);
		xo(16'h4000, 1'b0, 1'b1);
		xo(16'hC000, 1'b0, 1'b1);
		xo(16'h8000, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			pulse(i, 2);
			rd(ADDR_SUMMARY, d);
			chk("latch_set", d, 16'h0001 << sum_b[i]);
			rd(ADDR_SUMMARY, d);
			chk("sum_no_clear", d, 16'h0001 << sum_b[i]);
			rd(home_a[i], d);
			chk("home_read", d, home_v[i]);
			rd(ADDR_SUMMARY, d);
			chk("latch_cleared", d, 16'h0000);
			rd(home_a[i], d);
			chk("home_cleared", d, 16'h0000);
			chk("irq_masked", {15'h0000, o_irq}, 16'h0000);
		end
		rd(ADDR_IRQ_STAT, d);
		chk("irq_stat", d, 16'h0007);
		wr(ADDR_IRQ_MASK, 16'h0001);
		pulse(0, 1);
		tick(1);
		chk("irq_high", {15'h0000, o_irq}, 16'h0001);
		rd(ADDR_SUMMARY, d);
		chk("sum_irq", d, 16'h2080);
		rd(ADDR_IRQ_STAT, d);
		chk("irq_src", d, 16'h0001);
		tick(1);
		chk("irq_clear", {15'h0000, o_irq}, 16'h0000);
		rd(ADDR_RXE_CNT, d);
		raw_sd <= 1'b1;
		lock   <= 1'b1;
		tick(2);
		rd(ADDR_SUMMARY, d);
		rd(ADDR_SUMMARY, d);
		chk("sd_lock_up", d, 16'h0600);
		lock <= 1'b0;
		tick(1);
		lock <= 1'b1;
		tick(1);
		rd(ADDR_SUMMARY, d);
		chk("lock_held_low", d, 16'h0400);
		chk("sd_raw", {15'h0000, o_link_signal_detect}, 16'h0001);
		rd(ADDR_SUMMARY, d);
		chk("sd_lock_back", d, 16'h0600);
		wr(ADDR_PCS_CTRL, 16'h0100);
		wr(ADDR_IRQ_MASK, 16'h0008);
		lock <= 1'b0;
		tick(3);
		chk("sd_qualified", {15'h0000, o_link_signal_detect}, 16'h0000);
		chk("irq_sd_loss", {15'h0000, o_irq}, 16'h0001);
		rd(ADDR_IRQ_STAT, d);
		chk("irq_src_sd", d, 16'h0008);
		rd(ADDR_SUMMARY, d);
		chk("sd_loss_held", d, 16'h0080);
		lock <= 1'b1;
		tick(3);
		chk("sd_restored", {15'h0000, o_link_signal_detect}, 16'h0001);
		ev[0] <= 1'b1;
		rd(ADDR_RXE_CNT, d);
		ev[0] <= 1'b0;
		chk("cnt_cleared", d, 16'h0000);
		rd(ADDR_SUMMARY, d);
		chk("set_wins", d, 16'h2000);
		rd(ADDR_RXE_CNT, d);
		chk("cnt_set_wins", d, 16'h0001);
		test_done();
	end

endmodule : tb_phy_status_summary_upper

`default_nettype wire
